// ===== rtl/rtcis_pkg.sv
package rtcis_pkg;

  // Fixed 7-bit bus address; with the direction bit it reads as A3h / A2h
  localparam logic [6:0] SLV_ADDR   = 7'h51;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;

  // Which byte of the transfer is being received
  localparam logic [1:0] KIND_SLAVE = 2'h0;
  localparam logic [1:0] KIND_REG   = 2'h1;
  localparam logic [1:0] KIND_DATA  = 2'h2;

  // Idle bus level seen by the synchronisers at reset
  localparam logic       BUS_IDLE   = 1'b1;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACK  = 6'h04,
    ST_TX   = 6'h08,
    ST_MACK = 6'h10,
    ST_WAIT = 6'h20
  } rtcis_state_t;

endpackage : rtcis_pkg

// ===== rtl/rtcis_slave.sv
`timescale 1ns/1ps
// Contract
// - Write is start, address with write bit, register byte, data bytes, stop; all acked.
// - Read addressed with direction bit 1 returns data from the current pointer.
// - Pointer increments after every data byte sent in a read.
// - No limit on the number of bytes between start and stop.
// - Only the fixed 7-bit address (A3h read, A2h write) is answered.
// - Pointer also increments after every data byte written.
// - Master acks bytes it wants continued; no ack ends read, line released.
module rtcis_slave #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  // Clock and reset
  input  wire logic          I_SYS_CLK,
  input  wire logic          I_RST_N,
  // Serial bus pins, open drain
  input  wire logic          I_SCL,
  output logic               O_SCL_OE,
  input  wire logic          I_SDA,
  output logic               O_SDA_O,
  output logic               O_SDA_OE,
  // Register read side
  output logic [AW-1:0]      O_RD_ADDR,
  input  wire logic [DW-1:0] I_RD_DATA,
  // Register write side
  output logic               O_WR_VALID,
  input  wire logic          I_WR_READY,
  output logic [AW-1:0]      O_WR_ADDR,
  output logic [DW-1:0]      O_WR_DATA
);

  typedef struct packed {
    logic                  scl_m;
    logic                  sda_m;
    logic                  scl_s;
    logic                  sda_s;
    logic                  scl_p;
    logic                  sda_p;
    rtcis_pkg::rtcis_state_t st;
    logic [1:0]            kind;
    logic                  rw;
    logic [3:0]            cnt;
    logic [7:0]            sh;
    logic [AW-1:0]         ptr;
    logic                  mack;
    logic                  sda_oe;
    logic                  scl_oe;
    logic                  v0;
    logic                  v1;
    logic [AW+DW-1:0]      e0;
    logic [AW+DW-1:0]      e1;
  } rtcis_reg_t;

  rtcis_reg_t q;
  rtcis_reg_t d;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic pend;
  logic room;
  logic pop;
  logic byte_done;
  logic [7:0] rx_byte;
  logic push;

  assign scl_rise = q.scl_s & ~q.scl_p;
  assign scl_fall = ~q.scl_s & q.scl_p;
  assign start_c  = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop_c   = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  assign rx_byte  = q.sh;
  assign pop      = q.v0 & I_WR_READY;
  assign room     = ~q.v1 | pop;
  assign pend     = (q.st == rtcis_pkg::ST_RX) && (q.cnt == rtcis_pkg::BYTE_BITS)
                    && (scl_fall || q.scl_oe);
  // A data byte is only acknowledged once the buffer can take it
  assign byte_done = pend && ((q.kind != rtcis_pkg::KIND_DATA) || room);
  assign push      = byte_done && (q.kind == rtcis_pkg::KIND_DATA);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d       = q;
    d.scl_m = I_SCL;
    d.sda_m = I_SDA;
    d.scl_s = q.scl_m;
    d.sda_s = q.sda_m;
    d.scl_p = q.scl_s;
    d.sda_p = q.sda_s;
    d.scl_oe = 1'b0;

    // Write buffer drains first so a push in the same cycle sees the free slot
    if (pop) begin
      d.e0 = q.e1;
      d.v0 = q.v1;
      d.v1 = 1'b0;
    end

    if (start_c) begin
      d.st   = rtcis_pkg::ST_RX;
      d.kind = rtcis_pkg::KIND_SLAVE;
      d.cnt  = 4'h0;
    end else if (stop_c) begin
      d.st = rtcis_pkg::ST_IDLE;
    end else begin
      case (q.st)
        rtcis_pkg::ST_RX: begin
          if (scl_rise && q.cnt != rtcis_pkg::BYTE_BITS) begin
            d.sh  = {q.sh[6:0], q.sda_s};
            d.cnt = q.cnt + 4'h1;
          end
          if (byte_done) begin
            case (q.kind)
              rtcis_pkg::KIND_SLAVE: begin
                if (rx_byte[7:1] == rtcis_pkg::SLV_ADDR) begin
                  d.st = rtcis_pkg::ST_ACK;
                  d.rw = rx_byte[0];
                end else begin
                  d.st = rtcis_pkg::ST_WAIT;
                end
              end
              rtcis_pkg::KIND_REG: begin
                d.ptr = rx_byte[AW-1:0];
                d.st  = rtcis_pkg::ST_ACK;
              end
              default: begin
                // Address advances per written byte, wrapping from the top back to zero
                if (d.v0) begin
                  d.e1 = {q.ptr, rx_byte[DW-1:0]};
                  d.v1 = 1'b1;
                end else begin
                  d.e0 = {q.ptr, rx_byte[DW-1:0]};
                  d.v0 = 1'b1;
                end
                d.ptr = q.ptr + AW'(1);
                d.st  = rtcis_pkg::ST_ACK;
              end
            endcase
          end else if (pend) begin
            // Buffer full: stretch the clock low rather than lose the byte
            d.scl_oe = 1'b1;
          end
        end
        rtcis_pkg::ST_ACK: begin
          if (scl_fall) begin
            d.cnt = 4'h0;
            if (q.rw) begin
              d.st = rtcis_pkg::ST_TX;
              d.sh = I_RD_DATA;
            end else begin
              d.st   = rtcis_pkg::ST_RX;
              d.kind = (q.kind == rtcis_pkg::KIND_SLAVE) ? rtcis_pkg::KIND_REG
                                                         : rtcis_pkg::KIND_DATA;
            end
          end
        end
        rtcis_pkg::ST_TX: begin
          if (scl_fall) begin
            d.sh  = {q.sh[6:0], 1'b1};
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == rtcis_pkg::LAST_BIT) begin
              d.st  = rtcis_pkg::ST_MACK;
              d.ptr = q.ptr + AW'(1);
            end
          end
        end
        rtcis_pkg::ST_MACK: begin
          if (scl_rise) begin
            d.mack = ~q.sda_s;
          end
          if (scl_fall) begin
            d.cnt = 4'h0;
            if (q.mack) begin
              d.st = rtcis_pkg::ST_TX;
              d.sh = I_RD_DATA;
            end else begin
              d.st = rtcis_pkg::ST_WAIT;
            end
          end
        end
        rtcis_pkg::ST_WAIT: d.st = rtcis_pkg::ST_WAIT;
        rtcis_pkg::ST_IDLE: d.st = rtcis_pkg::ST_IDLE;
        default: d.st = rtcis_pkg::ST_IDLE;
      endcase
    end

    // Pin drive follows the next state so it changes with the clock fall
    d.sda_oe = (d.st == rtcis_pkg::ST_ACK) ||
               ((d.st == rtcis_pkg::ST_TX) && ~d.sh[7]);
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q       <= '0;
      q.scl_m <= rtcis_pkg::BUS_IDLE;
      q.sda_m <= rtcis_pkg::BUS_IDLE;
      q.scl_s <= rtcis_pkg::BUS_IDLE;
      q.sda_s <= rtcis_pkg::BUS_IDLE;
      q.scl_p <= rtcis_pkg::BUS_IDLE;
      q.sda_p <= rtcis_pkg::BUS_IDLE;
      q.st    <= rtcis_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign O_SCL_OE   = q.scl_oe;
  assign O_SDA_OE   = q.sda_oe;
  // Open drain: the pin is only ever pulled low
  assign O_SDA_O    = 1'b0;
  assign O_RD_ADDR  = q.ptr;
  assign O_WR_VALID = q.v0;
  assign O_WR_ADDR  = q.e0[AW+DW-1:DW];
  assign O_WR_DATA  = q.e0[DW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  a_addr_match_ack: assert property (
    byte_done && q.kind == rtcis_pkg::KIND_SLAVE && rx_byte[7:1] == rtcis_pkg::SLV_ADDR
    |=> q.st == rtcis_pkg::ST_ACK && O_SDA_OE && q.rw == $past(rx_byte[0]))
    else $error("matching address not acknowledged");

  a_addr_other_ignored: assert property (
    byte_done && q.kind == rtcis_pkg::KIND_SLAVE && rx_byte[7:1] != rtcis_pkg::SLV_ADDR
    |=> q.st == rtcis_pkg::ST_WAIT ##1 !O_SDA_OE)
    else $error("foreign address not ignored");

  a_wait_released: assert property (
    q.st == rtcis_pkg::ST_WAIT |-> !O_SDA_OE)
    else $error("data line driven while ignoring");

  a_reg_pointer_set: assert property (
    byte_done && q.kind == rtcis_pkg::KIND_REG |=> O_RD_ADDR == $past(rx_byte[AW-1:0]))
    else $error("register byte not loaded to pointer");

  a_write_incr: assert property (
    push |=> O_RD_ADDR == $past(O_RD_ADDR) + AW'(1) && O_WR_VALID)
    else $error("write did not advance pointer");

  a_read_first: assert property (
    q.st == rtcis_pkg::ST_ACK && q.rw && scl_fall && !start_c && !stop_c
    |=> q.st == rtcis_pkg::ST_TX && q.sh == $past(I_RD_DATA))
    else $error("read did not start from pointer");

  a_read_incr: assert property (
    q.st == rtcis_pkg::ST_TX && scl_fall && q.cnt == rtcis_pkg::LAST_BIT && !start_c
    && !stop_c |=> q.st == rtcis_pkg::ST_MACK && O_RD_ADDR == $past(O_RD_ADDR) + AW'(1)
    ##1 !O_SDA_OE)
    else $error("read byte did not advance pointer");

  a_nack_release: assert property (
    q.st == rtcis_pkg::ST_MACK && scl_fall && !q.mack && !start_c && !stop_c
    |=> q.st == rtcis_pkg::ST_WAIT ##1 !O_SDA_OE[*2])
    else $error("data line not released after no-ack");

  a_write_unbounded: assert property (
    q.st == rtcis_pkg::ST_ACK && !q.rw && q.kind == rtcis_pkg::KIND_DATA && scl_fall
    && !start_c && !stop_c |=> q.st == rtcis_pkg::ST_RX && q.cnt == 4'h0)
    else $error("write stopped accepting bytes");

endmodule // rtcis_slave

// ===== verif/rtcis_bus_master.sv
`timescale 1ns/1ps
module rtcis_bus_master (
  // Clock and wire levels
  input  wire logic i_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Open-drain pulls, high pulls the wire low
  output logic      o_scl_oe,
  output logic      o_sda_oe,
  output logic      o_hang
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
    o_hang   = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Also a repeated start: SDA and SCL are let go first
  task automatic start();
    o_sda_oe = 1'b0;
    hold(4);
    o_scl_oe = 1'b0;
    hold(8);
    o_sda_oe = 1'b1;
    hold(8);
    o_scl_oe = 1'b1;
    hold(4);
  endtask
  task automatic stop();
    o_sda_oe = 1'b1;
    hold(4);
    o_scl_oe = 1'b0;
    hold(8);
    o_sda_oe = 1'b0;
    hold(8);
  endtask
  // Low time of 8 clocks leaves the slave room to answer
  task automatic one_bit(input logic b, output logic r);
    int n;
    o_sda_oe = ~b;
    hold(6);
    o_scl_oe = 1'b0;
    for (n = 0; n < 4000 && i_scl !== 1'b1; n++) hold(1);
    if (n == 4000) o_hang = 1'b1;
    hold(8);
    r = i_sda;
    o_scl_oe = 1'b1;
    hold(2);
  endtask
  // Ninth bit: 1 releases SDA, 0 is a master acknowledge
  task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) one_bit(tx[i], rx[i]);
    one_bit(nine, ack);
  endtask
endmodule // rtcis_bus_master

// ===== verif/rtc_i2c_slave_transfer_tb_top.sv
`timescale 1ns/1ps
module rtc_i2c_slave_transfer_tb_top;
  logic        clk, rst_n, m_scl, m_sda, hang, s_scl, s_sda_o, s_sda, wv, wr;
  logic [7:0]  ra, wa, wd, p, ptr, rx;
  logic        ack;
  logic [7:0]  mem [256];
  logic [7:0]  model [256];
  logic [15:0] q [$];
  logic [7:0]  bad [4] = '{8'hA0, 8'hA1, 8'hA6, 8'h22};
  int          n_errors, comparisons, seed, stall;
  wire         scl = ~(m_scl | s_scl);
  wire         sda = ~(m_sda | (s_sda & ~s_sda_o));
  rtcis_slave u_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .O_SCL_OE(s_scl),
    .I_SDA(sda), .O_SDA_O(s_sda_o), .O_SDA_OE(s_sda), .O_RD_ADDR(ra), .I_RD_DATA(mem[ra]),
    .O_WR_VALID(wv), .I_WR_READY(wr), .O_WR_ADDR(wa), .O_WR_DATA(wd));
  rtcis_bus_master u_m (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl),
    .o_sda_oe(m_sda), .o_hang(hang));
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Consumer stalls at random, or for a long stretch when asked
  always @(negedge clk) begin
    if (stall > 0) stall <= stall - 1;
    wr <= (stall == 0) && ($random(seed) & 1);
  end
  always @(posedge clk) begin
    if (rst_n && wv && wr) begin
      chk("spurious write", q.size() != 0, 8'h01);
      chk("write addr", wa, q[0][15:8]);
      chk("write data", wd, q[0][7:0]);
      void'(q.pop_front());
      // Late update keeps the read port free of same-edge ordering races
      mem[wa] <= wd;
    end
  end
  always @(posedge hang) begin
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  task automatic wr_bytes(input int n);
    u_m.start();
    u_m.xfer(8'hA2, 1'b1, rx, ack);
    chk("write addr ack", ack, 8'h00);
    u_m.xfer(p, 1'b1, rx, ack);
    chk("pointer ack", ack, 8'h00);
    ptr = p;
    for (int i = 0; i < n; i++) begin
      model[ptr] = 8'($random(seed));
      q.push_back({ptr, model[ptr]});
      u_m.xfer(model[ptr], 1'b1, rx, ack);
      chk("data ack", ack, 8'h00);
      ptr++;
    end
  endtask
  task automatic rd_bytes(input int n);
    u_m.start();
    u_m.xfer(8'hA3, 1'b1, rx, ack);
    chk("read addr ack", ack, 8'h00);
    for (int i = 0; i < n; i++) begin
      u_m.xfer(8'hFF, i == n - 1, rx, ack);
      chk("read data", rx, model[ptr]);
      ptr++;
    end
    u_m.stop();
    chk("pointer", ra, ptr);
  endtask
  initial begin
    seed = 32'hdf7a;
    stall = 0;
    wr = 1'b0;
    rst_n = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (model[i]) model[i] = 8'h00;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("reset pointer", ra, 8'h00);
    chk("reset write valid", wv, 8'h00);
    for (int k = 0; k < 3; k++) begin
      // Wrap case first, then spots well below the test locations
      p = (k == 0) ? 8'hFE : 8'(8'h10 + ($random(seed) & 8'h1F));
      stall = (k == 1) ? 1500 : 0;
      wr_bytes(3 + k);
      u_m.stop();
      for (int n = 0; q.size() != 0; n++) begin
        if (n == 4000) begin
          n_errors++;
          print_verdict();
        end
        @(negedge clk);
      end
      wr_bytes(0);
      rd_bytes(3 + k);
      rd_bytes(2);
    end
    foreach (bad[i]) begin
      u_m.start();
      u_m.xfer(bad[i], 1'b1, rx, ack);
      chk("foreign ack", ack, 8'h01);
      u_m.xfer(8'h00, 1'b1, rx, ack);
      chk("foreign data ack", ack, 8'h01);
      u_m.stop();
    end
    chk("pointer kept", ra, ptr);
    chk("writes outstanding", q.size() != 0, 8'h00);
    print_verdict();
  end
endmodule // rtc_i2c_slave_transfer_tb_top
